// ### spi_far_end.sv
// behavioural far side of the serial port: slave when the port is master, master otherwise.
// assumes sck is the resolved clock wire and din the port's data-out line.
`timescale 1ns/1ps
module spi_far_end (
  input  wire logic       core_clk,
  input  wire logic       sck,
  input  wire logic       din,
  input  wire logic       pol,
  input  wire logic       edg,
  input  wire logic       msb,
  input  wire logic       is_master,
  output logic            sck_drv,
  output logic            sel_n,
  output logic            dout,
  output logic [7:0]      rx_word
);
  logic [7:0] tx;
  logic [3:0] bits;
  logic       din_q;
  function automatic logic pick(logic [7:0] w, logic [3:0] i, logic m);
    return m ? w[3'd7 - i[2:0]] : w[i[2:0]];
  endfunction
  initial begin
    sck_drv = 1'b1;
    sel_n = 1'b1;
    dout = 1'b0;
    rx_word = 8'h00;
    bits = 4'h0;
    tx = 8'h00;
  end
  // sampled on the falling core edge so a same-edge shift never races the capture
  always @(negedge core_clk) din_q <= din;
  always @(sck) begin
    if (sck === (pol ~^ edg)) begin
      rx_word = msb ? {rx_word[6:0], din_q} : {din_q, rx_word[7:1]};
      bits = bits + 4'h1;
      if (!is_master && bits < 4'h8) dout = pick(tx, bits, msb);
    end else if (is_master && bits < 4'h8) dout = pick(tx, bits, msb);
  end
  task automatic arm(input logic [7:0] w);
    sck_drv = ~pol;
    #1;
    tx = w;
    bits = 4'h0;
    rx_word = 8'h00;
    dout = pick(w, 4'h0, msb);
  endtask
  task automatic drive(input int n, input logic keep_high);
    sel_n = keep_high;
    #400;
    repeat (2 * n) begin
      sck_drv = ~sck_drv;
      #200;
    end
    sel_n = 1'b1;
    // a released line must not keep showing its last bit
    dout = ~dout;
  endtask
endmodule // spi_far_end

// ### spi_master_slave_port.sv
// four-wire serial port, master or slave, one 8-bit word per transfer,
// with its three registers on an AXI4-Lite slave.
// assumes pins, the sub clock and the link clock are asynchronous to core_clk;
// timer_period_match is a one-cycle pulse from logic on core_clk.
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps

// Overview of operation
// - mode field: 000 /4, 001 /16, 010 /64, 011 sub, 100 timer/2, 101 slave, 11x off
// - enable clear releases all four pins and holds the port inactive
// - slave select rising mid-word sets incomplete and complete flags
// - software writing one to incomplete flag does not set complete flag
// - unused control bits read as zero
// - master clock idles high for polarity 0, low for polarity 1
// - edge bit with polarity picks the rising or falling sampling edge
// - order bit 1 shifts msb first, 0 shifts lsb first
// - select-enable bit decides whether the select pin is used
// - data write during a transfer is dropped and sets sticky collision flag
// - complete flag set at end of each word, cleared only by software
// - master: data write starts clock, shifting out and in together
// - slave: shift data out and data in on external clocks
// - slave floats data out while deselected; first bit shows on write
// - slave with select disabled stays active regardless of select level
// - one data register; a read returns the last received word
// - port keeps working while its clock source runs
// - enabled idle master floats data in and drives data out high
// - slave never drives the serial clock pin
module spi_master_slave_port
  import spi_port_pkg::*;
(
  input  wire logic                          core_clk,
  input  wire logic                          rstn,
  input  wire logic [spi_port_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [spi_port_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic                          serial_clock_pin_level,
  output logic                               serial_clock_pin_value,
  output logic                               serial_clock_pin_oe,
  input  wire logic                          serial_data_in_pin,
  output logic                               serial_data_out_pin,
  output logic                               serial_data_out_pin_oe,
  input  wire logic                          slave_select_pin_n,
  output logic                               select_pin_claimed,
  output logic                               port_pins_claimed,
  input  wire logic                          sub_clk,
  input  wire logic                          timer_period_match
);
  import spi_port_pkg::*;

  typedef struct packed {
    xfer_state_t st;
    logic [2:0]  mode;
    logic        en;
    logic        icf;
    logic        pol;
    logic        edge_sel;
    logic        order;
    logic        csen;
    logic        wcol;
    logic        trf;
    logic [7:0]  data;
    logic [7:0]  shreg;
    logic [3:0]  bits;
    logic [4:0]  toggles;
    logic [5:0]  div;
    logic        sck;
    logic [1:0]  sck_sync;
    logic        sck_prev;
    logic [1:0]  ss_sync;
    logic        ss_prev;
    logic [1:0]  sub_sync;
    logic        sub_prev;
    logic [1:0]  sdi_sync;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } state_t;

  localparam state_t RST_STATE = '{st: ST_IDLE, mode: MODE_RST, data: DATA_RST, shreg: DATA_RST,
                                   bresp: RESP_OKAY, rresp: RESP_OKAY, default: '0};

  function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
    if (a == ADDR_DATA) begin
      return SEL_DATA;
    end else if (a == ADDR_CTRL0) begin
      return SEL_CTRL0;
    end else if (a == ADDR_CTRL1) begin
      return SEL_CTRL1;
    end else begin
      return SEL_NONE;
    end
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic msb_first, input logic b);
    return msb_first ? {v[6:0], b} : {b, v[7:1]};
  endfunction

  state_t      q;
  state_t      d;
  logic        master_on;
  logic        slave_on;
  logic        slave_sel;
  logic        busy;
  logic        sample_rising;
  logic        tick;
  logic        samp_m;
  logic        samp_s;
  logic        start_m;
  logic        master_done;
  logic        slave_done;
  logic        slave_abort;
  logic        wr_go;
  logic        wr_lane0;
  logic        wcol_set;
  logic [1:0]  wsel;
  logic [1:0]  rsel;
  logic [7:0]  new_shreg;
  logic        out_bit;

  assign master_on     = q.en && (q.mode <= MODE_TIMER);
  assign slave_on      = q.en && (q.mode == MODE_SLAVE);
  assign slave_sel     = slave_on && (!q.csen || !q.ss_sync[1]);
  assign busy          = (q.st == ST_RUN);
  assign sample_rising = (q.pol == q.edge_sel);
  assign out_bit       = q.order ? q.shreg[7] : q.shreg[0];
  assign wr_go         = s_axi_awvalid && s_axi_wvalid && !q.bvalid;
  assign wr_lane0      = wr_go && s_axi_wstrb[0];
  assign wsel          = reg_sel(s_axi_awaddr);
  assign rsel          = reg_sel(s_axi_araddr);

  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rresp   = q.rresp;
  assign s_axi_rdata   = q.rdata;

  // master drives its clock whenever enabled, at the idle level between words,
  // so the line never floats; a slave leaves it alone
  assign serial_clock_pin_value = q.sck;
  assign serial_clock_pin_oe    = master_on;
  assign serial_data_out_pin    = (master_on && !busy) ? 1'b1 : out_bit;
  assign serial_data_out_pin_oe = master_on || slave_sel;
  assign select_pin_claimed     = (master_on || slave_on) && q.csen;
  assign port_pins_claimed      = master_on || slave_on;

  always_comb begin
    d           = q;
    tick        = 1'b0;
    samp_m      = 1'b0;
    samp_s      = 1'b0;
    start_m     = 1'b0;
    master_done = 1'b0;
    slave_done  = 1'b0;
    slave_abort = 1'b0;
    wcol_set    = 1'b0;
    new_shreg   = q.shreg;

    d.sck_sync = {q.sck_sync[0], serial_clock_pin_level};
    d.sck_prev = q.sck_sync[1];
    d.ss_sync  = {q.ss_sync[0], slave_select_pin_n};
    d.ss_prev  = q.ss_sync[1];
    d.sub_sync = {q.sub_sync[0], sub_clk};
    d.sub_prev = q.sub_sync[1];
    d.sdi_sync = {q.sdi_sync[0], serial_data_in_pin};

    // half-bit tick of the chosen master source; runs as long as that source does
    case (q.mode)
      MODE_DIV4:  tick = (q.div == HALF_DIV4 - 6'h01);
      MODE_DIV16: tick = (q.div == HALF_DIV16 - 6'h01);
      MODE_DIV64: tick = (q.div == HALF_DIV64 - 6'h01);
      MODE_SUB:   tick = q.sub_sync[1] ^ q.sub_prev;
      MODE_TIMER: tick = timer_period_match;
      default:    tick = 1'b0;
    endcase

    if (master_on) begin
      if (busy) begin
        d.div  = tick ? 6'h00 : q.div + 6'h01;
        samp_m = tick && ((~q.sck) == sample_rising);
        if (tick) begin
          d.sck     = ~q.sck;
          d.toggles = q.toggles + 5'h01;
          if (samp_m) begin
            new_shreg = shift_in(q.shreg, q.order, q.sdi_sync[1]);
            d.bits    = q.bits + 4'h1;
          end
          if (q.toggles == EDGES_PER_WORD - 5'h01) begin
            master_done = 1'b1;
            d.st        = ST_IDLE;
            d.data      = new_shreg;
            d.bits      = 4'h0;
          end
        end
      end else begin
        // changing polarity mid-word would glitch the clock; software avoids it
        d.sck = ~q.pol;
      end
    end else if (slave_on) begin
      d.sck  = ~q.pol;
      samp_s = slave_sel && (sample_rising ? (q.sck_sync[1] && !q.sck_prev)
                                           : (!q.sck_sync[1] && q.sck_prev));
      if (samp_s) begin
        new_shreg = shift_in(q.shreg, q.order, q.sdi_sync[1]);
        d.bits    = q.bits + 4'h1;
        d.st      = ST_RUN;
        if (q.bits == BITS_PER_WORD - 4'h1) begin
          slave_done = 1'b1;
          d.st       = ST_IDLE;
          d.bits     = 4'h0;
          d.data     = new_shreg;
        end
      end else if (q.csen && q.ss_sync[1] && !q.ss_prev && busy) begin
        slave_abort = 1'b1;
        d.st        = ST_IDLE;
        d.bits      = 4'h0;
      end
    end else begin
      d.st   = ST_IDLE;
      d.bits = 4'h0;
      // track polarity while off, so enabling the master shows no stray edge
      d.sck  = ~q.pol;
    end
    d.shreg = new_shreg;

    // register writes; only byte lane 0 carries the 8-bit registers
    if (wr_lane0) begin
      if (wsel == SEL_DATA) begin
        if (busy) begin
          wcol_set = 1'b1;
        end else begin
          d.shreg = s_axi_wdata[7:0];
          if (master_on) begin
            start_m   = 1'b1;
            d.st      = ST_RUN;
            d.div     = 6'h00;
            d.toggles = 5'h00;
            d.bits    = 4'h0;
          end
        end
      end else if (wsel == SEL_CTRL0) begin
        d.mode = s_axi_wdata[C0_MODE_LSB +: 3];
        d.en   = s_axi_wdata[C0_EN_BIT];
        d.icf  = s_axi_wdata[C0_ICF_BIT];
      end else if (wsel == SEL_CTRL1) begin
        d.pol      = s_axi_wdata[C1_POL_BIT];
        d.edge_sel = s_axi_wdata[C1_EDGE_BIT];
        d.order    = s_axi_wdata[C1_ORDER_BIT];
        d.csen     = s_axi_wdata[C1_CSEN_BIT];
        d.wcol     = s_axi_wdata[C1_WCOL_BIT];
        d.trf      = s_axi_wdata[C1_TRF_BIT];
      end
    end
    // hardware events win over a software clear in the same cycle
    if (wcol_set) begin
      d.wcol = 1'b1;
    end
    if (master_done || slave_done || slave_abort) begin
      d.trf = 1'b1;
    end
    if (slave_abort) begin
      d.icf = 1'b1;
    end

    if (wr_go) begin
      d.bvalid = 1'b1;
      d.bresp  = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    if (s_axi_arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      if (rsel == SEL_DATA) begin
        d.rdata = {24'h000000, q.data};
      end else if (rsel == SEL_CTRL0) begin
        d.rdata = {24'h000000, q.mode, 3'h0, q.en, q.icf};
      end else if (rsel == SEL_CTRL1) begin
        d.rdata = {24'h000000, 2'h0, q.pol, q.edge_sel, q.order, q.csen, q.wcol, q.trf};
      end else begin
        d.rdata = 32'h00000000;
        d.rresp = RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_first_half_div4;
    $stable(q.sck)[*2] ##1 $changed(q.sck);
  endsequence

  sequence s_flags_both;
    q.icf && q.trf;
  endsequence

  a_div_four_tick:
    assert property (start_m && q.mode == MODE_DIV4 |=> s_first_half_div4)
      else $error("divide-by-4 first clock half not two cycles");

  a_pins_released:
    assert property (!q.en |-> !serial_clock_pin_oe && !serial_data_out_pin_oe && !port_pins_claimed)
      else $error("pins driven while port disabled");

  a_abort_flags:
    assert property (slave_abort |=> s_flags_both)
      else $error("slave abort did not set both flags");

  a_sw_icf_no_trf:
    assert property (wr_lane0 && wsel == SEL_CTRL0 && !master_done && !slave_done && !slave_abort
                     |=> q.trf == $past(q.trf))
      else $error("complete flag changed by control zero write");

  a_idle_level:
    assert property (master_on && !busy && $stable(q.pol) |=> serial_clock_pin_value == ~$past(q.pol))
      else $error("master clock not at idle level");

  a_collision_kept:
    assert property (wr_lane0 && wsel == SEL_DATA && busy |=> q.wcol && q.shreg == $past(new_shreg))
      else $error("collision not flagged or shift data overwritten");

  a_done_latch:
    assert property (master_done || slave_done |=> q.trf && q.data == $past(new_shreg))
      else $error("word end did not set flag or latch data");

  a_eight_bits:
    assert property (master_done |-> (q.bits + {3'h0, samp_m}) == BITS_PER_WORD)
      else $error("master word not eight bits");

  a_slave_float:
    assert property (slave_on && q.csen && q.ss_sync[1] |-> !serial_data_out_pin_oe && !serial_clock_pin_oe)
      else $error("deselected slave drives a pin");

  a_slave_clock_in:
    assert property (slave_on |-> !serial_clock_pin_oe)
      else $error("slave drives the clock pin");

  a_idle_data_high:
    assert property (master_done |=> serial_data_out_pin && serial_data_out_pin_oe)
      else $error("master data out not high after word");

endmodule // spi_master_slave_port

// ### spi_port_pkg.sv
// constants for the four-wire serial port: register map, field positions,
// reset values, clock modes and bit-clock dividers.
// assumes a 20 MHz core clock and a 32-bit AXI4-Lite register bus.
package spi_port_pkg;

  localparam int          ADDR_W        = 4;
  localparam logic [3:0]  ADDR_DATA     = 4'h0;
  localparam logic [3:0]  ADDR_CTRL0    = 4'h4;
  localparam logic [3:0]  ADDR_CTRL1    = 4'h8;

  // register select codes from the address decoder
  localparam logic [1:0]  SEL_DATA      = 2'h0;
  localparam logic [1:0]  SEL_CTRL0     = 2'h1;
  localparam logic [1:0]  SEL_CTRL1     = 2'h2;
  localparam logic [1:0]  SEL_NONE      = 2'h3;

  // serial_control_zero fields
  localparam int          C0_MODE_LSB   = 5;
  localparam int          C0_EN_BIT     = 1;
  localparam int          C0_ICF_BIT    = 0;
  // serial_control_one fields
  localparam int          C1_POL_BIT    = 5;
  localparam int          C1_EDGE_BIT   = 4;
  localparam int          C1_ORDER_BIT  = 3;
  localparam int          C1_CSEN_BIT   = 2;
  localparam int          C1_WCOL_BIT   = 1;
  localparam int          C1_TRF_BIT    = 0;

  // clock_mode_select encodings
  localparam logic [2:0]  MODE_DIV4     = 3'h0;
  localparam logic [2:0]  MODE_DIV16    = 3'h1;
  localparam logic [2:0]  MODE_DIV64    = 3'h2;
  localparam logic [2:0]  MODE_SUB      = 3'h3;
  localparam logic [2:0]  MODE_TIMER    = 3'h4;
  localparam logic [2:0]  MODE_SLAVE    = 3'h5;

  localparam logic [2:0]  MODE_RST      = 3'h7;
  localparam logic [7:0]  DATA_RST      = 8'h00;

  // core cycles per half bit clock in the divided master modes
  localparam logic [5:0]  HALF_DIV4     = 6'h02;
  localparam logic [5:0]  HALF_DIV16    = 6'h08;
  localparam logic [5:0]  HALF_DIV64    = 6'h20;

  localparam logic [3:0]  BITS_PER_WORD = 4'h8;
  localparam logic [4:0]  EDGES_PER_WORD = 5'h10;

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } xfer_state_t;

endpackage

// ### tb_spi_master_slave_port.sv
// testbench for the serial port: register accesses over AXI4-Lite, far side in spi_far_end.
// assumes the package constants for addresses, modes and response codes.
`timescale 1ns/1ps
module tb_spi_master_slave_port;
  import spi_port_pkg::*;
  logic core_clk = 1'b0, rstn = 1'b0, sub_clk = 1'b0, tmr = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [1:0] bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid, sck_val, sck_oe, sdo, sdo_oe, sel_claim, pins_claim;
  logic pol = 1'b0, edg = 1'b0, msb = 1'b0, p_master = 1'b0;
  logic p_sck, p_sel, p_dout;
  logic [7:0] p_rx, tx_b, rx_b;
  logic [2:0] tcnt = 3'h0;
  int err_total = 0, total_checks = 0;
  wire sck_w = sck_oe ? sck_val : p_sck;
  always #25 core_clk = ~core_clk;
  always #500 sub_clk = ~sub_clk;
  always @(posedge core_clk) begin
    tcnt <= tcnt + 3'h1;
    tmr <= (tcnt == 3'h3);
  end
  spi_master_slave_port dut_u (
    .core_clk(core_clk), .rstn(rstn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_clock_pin_level(sck_w), .serial_clock_pin_value(sck_val), .serial_clock_pin_oe(sck_oe),
    .serial_data_in_pin(p_dout), .serial_data_out_pin(sdo), .serial_data_out_pin_oe(sdo_oe),
    .slave_select_pin_n(p_sel), .select_pin_claimed(sel_claim), .port_pins_claimed(pins_claim),
    .sub_clk(sub_clk), .timer_period_match(tmr)
  );
  spi_far_end far_u (
    .core_clk(core_clk), .sck(sck_w), .din(sdo_oe ? sdo : ~sdo), .pol(pol), .edg(edg), .msb(msb),
    .is_master(p_master), .sck_drv(p_sck), .sel_n(p_sel), .dout(p_dout), .rx_word(p_rx)
  );
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(negedge core_clk); while (!(awready === 1'b1 && wready === 1'b1));
    @(posedge core_clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge core_clk); while (bvalid !== 1'b1);
    resp = bresp;
    @(posedge core_clk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge core_clk); while (arready !== 1'b1);
    @(posedge core_clk);
    arvalid <= 1'b0;
    do @(negedge core_clk); while (rvalid !== 1'b1);
    rv = rdata;
    resp = rresp;
    @(posedge core_clk);
    rready <= 1'b0;
  endtask
  task automatic wait_trf();
    rv = 32'h0;
    for (int i = 0; i < 400 && rv[0] !== 1'b1; i++) rd(ADDR_CTRL1);
    chk(32'(rv[0]), 32'h1);
  endtask
  // port off while polarity changes, so no stray edge reaches either end
  task automatic cfg(input logic p, input logic e, input logic o, input logic cs, input logic [2:0] m,
                     input logic [7:0] w);
    wr(ADDR_CTRL0, 8'he0);
    pol <= p;
    edg <= e;
    msb <= o;
    p_master <= (m == MODE_SLAVE);
    wr(ADDR_CTRL1, {2'b00, p, e, o, cs, 2'b00});
    far_u.arm(w);
    wr(ADDR_CTRL0, {m, 5'b11110});
    rd(ADDR_CTRL0);
    chk(rv, {24'h0, m, 5'b00010});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #3000000;
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    wr(4'hc, 8'hff);
    chk(32'(resp), 32'(RESP_SLVERR));
    rd(ADDR_CTRL0);
    chk(rv, 32'he0);
    rd(ADDR_CTRL1);
    chk(rv, 32'h0);
    chk(32'(pins_claim), 32'h0);
    rd(4'hc);
    chk(32'(resp), 32'(RESP_SLVERR));
    $display("reset and map test done");
    for (int m = 0; m < 5; m++) begin
      tx_b = 8'hc5 + 8'(m);
      rx_b = 8'h3a - 8'(m);
      cfg(m[0], m[1], m[0] ~^ m[2], 1'b0, 3'(m), rx_b);
      @(negedge core_clk);
      chk(32'({sck_oe, sck_val, sdo_oe, sdo}), 32'({1'b1, ~pol, 2'b11}));
      wr(ADDR_DATA, tx_b);
      if (m == 2) wr(ADDR_DATA, 8'h00);
      wait_trf();
      rd(ADDR_DATA);
      chk(rv, {24'h0, rx_b});
      chk(32'(p_rx), 32'(tx_b));
      rd(ADDR_CTRL1);
      chk(32'(rv[1:0]), 32'({m == 2, 1'b1}));
      $display("master test done, mode %0d", m);
    end
    cfg(1'b0, 1'b0, 1'b1, 1'b0, MODE_SLAVE, 8'h5c);
    wr(ADDR_DATA, 8'h96);
    @(negedge core_clk);
    chk(32'({sel_claim, sck_oe, sdo_oe, sdo}), 32'h3);
    far_u.drive(8, 1'b1);
    wait_trf();
    rd(ADDR_DATA);
    chk(rv, 32'h5c);
    chk(32'(p_rx), 32'h96);
    $display("slave without select test done");
    cfg(1'b1, 1'b1, 1'b0, 1'b1, MODE_SLAVE, 8'ha3);
    wr(ADDR_DATA, 8'h4b);
    @(negedge core_clk);
    chk(32'({sel_claim, sdo_oe}), 32'h2);
    far_u.drive(8, 1'b0);
    wait_trf();
    rd(ADDR_DATA);
    chk(rv, 32'ha3);
    chk(32'(p_rx), 32'h4b);
    wr(ADDR_CTRL1, 8'h34);
    far_u.arm(8'hff);
    far_u.drive(3, 1'b0);
    wait_trf();
    rd(ADDR_CTRL0);
    chk(32'(rv[0]), 32'h1);
    wr(ADDR_CTRL1, 8'h34);
    wr(ADDR_CTRL0, {MODE_SLAVE, 5'b00011});
    rd(ADDR_CTRL1);
    chk(32'(rv[0]), 32'h0);
    $display("slave abort test done");
    wr(ADDR_CTRL0, 8'hc2);
    @(negedge core_clk);
    chk(32'({pins_claim, sel_claim, sdo_oe, sck_oe}), 32'h0);
    wr(ADDR_CTRL0, 8'h00);
    @(negedge core_clk);
    chk(32'({pins_claim, sel_claim, sdo_oe, sck_oe}), 32'h0);
    $display("disable test done");
    end_of_test();
  end
endmodule // tb_spi_master_slave_port
